// ==== verilog/sbfw_buffer_ctrl.sv ====
// Sample store with purge, fill watermark and keep-awake control
`include "sbfw_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module sbfw_buffer_ctrl #(
	parameter int DATA_W = `SBFW_DATA_W,
	parameter int DEPTH  = `SBFW_DEPTH
) (
	input  wire logic              CLK,
	input  wire logic              NRST,
	input  wire logic [7:0]        REG_ADDR,
	input  wire logic              REG_WR,
	input  wire logic [7:0]        REG_WDATA,
	input  wire logic              REG_RD,
	output logic      [7:0]        REG_RDATA,
	input  wire logic [1:0]        BUF_MODE,
	input  wire logic              TRIG_EVENT,
	input  wire logic              S_VALID,
	input  wire logic [DATA_W-1:0] S_DATA,
	output logic                   S_READY,
	input  wire logic              POP_REQ,
	output logic      [DATA_W-1:0] POP_DATA,
	output logic                   POP_VALID,
	output logic      [5:0]        FILL_COUNT,
	output logic                   WATERMARK_FLAG,
	output logic                   OVERRUN_FLAG,
	input  wire logic              TIMER_EXPIRED,
	output logic                   TIMER_RESTART,
	output logic                   SLEEP_ENTER,
	output logic                   BUF_ACTIVITY,
	output logic                   GATE_CLEAR
);

	localparam int PW = $clog2(DEPTH);
	localparam int CW = PW + 1;
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

	// ****************************************************************
	// State
	// ****************************************************************
	sbfw_pkg::sbfw_ctrl_t  ctrl, next_ctrl;
	sbfw_pkg::sbfw_stat_t  stat, next_stat;
	sbfw_pkg::sbfw_phase_t phase, next_phase;
	logic [DATA_W-1:0]     mem [DEPTH];
	logic [DATA_W-1:0]     skid [`SBFW_SKID_DEPTH];
	logic [PW-1:0]         head, next_head, tail, next_tail;
	logic [CW-1:0]         cnt, next_cnt, post_cnt, next_post_cnt;
	logic [1:0]            sk_cnt, next_sk_cnt;
	logic                  sk_wp, next_sk_wp, sk_rp, next_sk_rp;
	logic [7:0]            next_rdata;
	logic [DATA_W-1:0]     next_pop_data;
	logic                  next_pop_valid, next_ready;
	logic                  next_restart, next_sleep, next_act, next_gclr;
	logic                  purge, push, pop, drop, drain, ovf_set;
	logic                  relevant, flag_clear, ctrl_hit;
	logic [CW-1:0]         thr_c, post_target;
	sbfw_pkg::sbfw_mode_t  mode;

	// ****************************************************************
	// Next-state computation
	// ****************************************************************
	// All datapath and flag decisions in one place for priority clarity
	always_comb
	begin
		mode          = sbfw_pkg::sbfw_mode_t'(BUF_MODE);
		ctrl_hit      = REG_ADDR == `SBFW_CTRL_ADDR;
		thr_c         = CW'(ctrl.fill_threshold);
		// Threshold at or above depth leaves no room after the trigger
		post_target   = (thr_c >= FULL_CNT) ? '0 : FULL_CNT - thr_c;
		next_ctrl     = ctrl;
		next_phase    = phase;
		next_head     = head;
		next_tail     = tail;
		next_post_cnt = post_cnt;
		next_sk_cnt   = sk_cnt;
		next_sk_wp    = sk_wp;
		next_sk_rp    = sk_rp;
		next_pop_data = POP_DATA;
		push          = 1'b0;
		drop          = 1'b0;
		drain         = 1'b0;
		ovf_set       = 1'b0;
		if (REG_WR && ctrl_hit)
		begin
			next_ctrl = sbfw_pkg::sbfw_ctrl_t'(REG_WDATA[`SBFW_WAKE_BIT:0]);
		end
		// purge acts for one cycle only, never stored
		purge = REG_WR && ctrl_hit && REG_WDATA[`SBFW_PURGE_BIT];
		if (mode == sbfw_pkg::SBFW_OFF)
		begin
			purge = 1'b1;
		end
		pop = POP_REQ && (cnt != '0);
		// Store policy decides whether the waiting word may drain
		if (sk_cnt != 2'b00)
		begin
			unique case (mode)
				sbfw_pkg::SBFW_OFF:
				begin
					drain = 1'b1;
				end
				sbfw_pkg::SBFW_STREAM:
				begin
					drain = 1'b1;
					push  = 1'b1;
					// Oldest word gives way when full
					drop  = (cnt == FULL_CNT) && !pop;
					ovf_set = cnt == FULL_CNT;
				end
				sbfw_pkg::SBFW_STOP:
				begin
					// Full store stalls the source via the skid buffer
					drain   = (cnt != FULL_CNT) || pop;
					push    = drain;
					ovf_set = cnt == FULL_CNT;
				end
				sbfw_pkg::SBFW_TRIG:
				begin
					drain = 1'b1;
					unique case (phase)
						sbfw_pkg::SBFW_ARMED:
						begin
							push = thr_c != '0;
							drop = push && (cnt >= thr_c) && !pop;
						end
						sbfw_pkg::SBFW_POST:
						begin
							push = 1'b1;
						end
						default:
						begin
							push = 1'b0;
						end
					endcase
				end
			endcase
		end
		unique case (phase)
			sbfw_pkg::SBFW_ARMED:
			begin
				if (mode == sbfw_pkg::SBFW_TRIG && TRIG_EVENT)
				begin
					next_post_cnt = '0;
					next_phase    = (post_target == '0) ? sbfw_pkg::SBFW_HALT
						: sbfw_pkg::SBFW_POST;
					ovf_set       = ovf_set || (post_target == '0);
				end
			end
			sbfw_pkg::SBFW_POST:
			begin
				if (push)
				begin
					next_post_cnt = post_cnt + 1'b1;
					if (next_post_cnt >= post_target)
					begin
						next_phase = sbfw_pkg::SBFW_HALT;
						ovf_set    = 1'b1;
					end
				end
			end
			sbfw_pkg::SBFW_HALT:
			begin
				// Rearm once emptied by reads
				if (pop && cnt == CW'(1) && !push)
				begin
					next_phase = sbfw_pkg::SBFW_ARMED;
				end
			end
			default:
			begin
				next_phase = sbfw_pkg::SBFW_ARMED;
			end
		endcase
		if (mode != sbfw_pkg::SBFW_TRIG)
		begin
			next_phase = sbfw_pkg::SBFW_ARMED;
		end
		// Pointer and count update
		if (pop || drop)
		begin
			next_head = head + 1'b1;
		end
		if (push)
		begin
			next_tail = tail + 1'b1;
		end
		if (pop)
		begin
			next_pop_data = mem[head];
		end
		next_cnt = cnt + CW'(push) - CW'(pop || drop);
		// Skid buffer bookkeeping
		if (drain)
		begin
			next_sk_rp = ~sk_rp;
		end
		if (S_VALID && S_READY)
		begin
			next_sk_wp = ~sk_wp;
		end
		next_sk_cnt = sk_cnt + 2'(S_VALID && S_READY) - 2'(drain);
		// purge empties store and clears flags
		// purge overrides a store in the same cycle
		if (purge)
		begin
			next_head     = '0;
			next_tail     = '0;
			next_cnt      = '0;
			next_sk_cnt   = 2'b00;
			next_sk_wp    = 1'b0;
			next_sk_rp    = 1'b0;
			next_phase    = sbfw_pkg::SBFW_ARMED;
			next_post_cnt = '0;
		end
		next_ready = next_sk_cnt != 2'(`SBFW_SKID_DEPTH);
		next_stat.fill = 6'(next_cnt);
		// recomputed every cycle from the new values
		next_stat.watermark = (next_ctrl.fill_threshold != '0)
			&& (next_cnt >= CW'(next_ctrl.fill_threshold));
		// New overrun beats a read clear; purge clears outright
		next_stat.overrun_flag = !purge
			&& (ovf_set || (stat.overrun_flag && !pop));
		// keep-awake select only in stream or stop
		relevant = ctrl.keep_awake_select
			&& (mode == sbfw_pkg::SBFW_STREAM || mode == sbfw_pkg::SBFW_STOP);
		flag_clear = (purge || pop) && (stat.watermark || stat.overrun_flag);
		// host clearing flags restarts the sleep timer
		next_restart = relevant && flag_clear;
		// flags ignored when select is low
		// OR of flags counts as activity
		next_act = relevant && (next_stat.watermark || next_stat.overrun_flag);
		// uncleared flags do not hold off sleep
		next_sleep = TIMER_EXPIRED && !(relevant && flag_clear);
		// gate error and gated counter cleared by purge
		// also cleared when the last sample is read out
		next_gclr = purge || (pop && cnt == CW'(1) && !push);
		next_pop_valid = pop && !purge;
		// purge bit position always reads zero
		next_rdata = `SBFW_RD_ZERO;
		if (REG_RD && ctrl_hit)
		begin
			next_rdata = {1'b0, ctrl};
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	// Control and status flops, synchronous active-low reset
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			ctrl           <= sbfw_pkg::sbfw_ctrl_t'(`SBFW_CTRL_RESET);
			stat           <= '0;
			phase          <= sbfw_pkg::SBFW_ARMED;
			head           <= '0;
			tail           <= '0;
			cnt            <= '0;
			post_cnt       <= '0;
			sk_cnt         <= 2'b00;
			sk_wp          <= 1'b0;
			sk_rp          <= 1'b0;
			REG_RDATA      <= `SBFW_RD_ZERO;
			POP_DATA       <= '0;
			POP_VALID      <= 1'b0;
			S_READY        <= 1'b0;
			TIMER_RESTART  <= 1'b0;
			SLEEP_ENTER    <= 1'b0;
			BUF_ACTIVITY   <= 1'b0;
			GATE_CLEAR     <= 1'b0;
		end
		else
		begin
			ctrl           <= next_ctrl;
			stat           <= next_stat;
			phase          <= next_phase;
			head           <= next_head;
			tail           <= next_tail;
			cnt            <= next_cnt;
			post_cnt       <= next_post_cnt;
			sk_cnt         <= next_sk_cnt;
			sk_wp          <= next_sk_wp;
			sk_rp          <= next_sk_rp;
			REG_RDATA      <= next_rdata;
			POP_DATA       <= next_pop_data;
			POP_VALID      <= next_pop_valid;
			S_READY        <= next_ready;
			TIMER_RESTART  <= next_restart;
			SLEEP_ENTER    <= next_sleep;
			BUF_ACTIVITY   <= next_act;
			GATE_CLEAR     <= next_gclr;
		end
	end

	// Sample storage; data words need no reset, pointers guard them
	always_ff @(posedge CLK)
	begin
		if (push && !purge)
		begin
			mem[tail] <= skid[sk_rp];
		end
		if (S_VALID && S_READY)
		begin
			skid[sk_wp] <= S_DATA;
		end
	end

	// Status outputs straight from the status flops
	assign FILL_COUNT     = stat.fill;
	assign WATERMARK_FLAG = stat.watermark;
	assign OVERRUN_FLAG   = stat.overrun_flag;

endmodule : sbfw_buffer_ctrl

`default_nettype wire

// ==== verilog/sbfw_cfg.svh ====
// Constants for the sample buffer purge and watermark control block
`ifndef SBFW_CFG_SVH
`define SBFW_CFG_SVH

// ****************************************************************
// Register map and field layout
// ****************************************************************
`define SBFW_CTRL_ADDR   8'h27
`define SBFW_PURGE_BIT   7
`define SBFW_WAKE_BIT    6
`define SBFW_THR_MSB     5
`define SBFW_THR_W       6
`define SBFW_CTRL_RESET  7'h00
`define SBFW_RD_ZERO     8'h00

// ****************************************************************
// Storage geometry
// ****************************************************************
`define SBFW_DEPTH       32
`define SBFW_DATA_W      36
`define SBFW_SKID_DEPTH  2

`endif

// ==== verilog/sbfw_pkg.sv ====
// Types shared by the sample buffer purge and watermark control block
`default_nettype none

package sbfw_pkg;

	// ****************************************************************
	// Store policies and triggered-mode phases
	// ****************************************************************
	typedef enum logic [1:0] {
		SBFW_OFF    = 2'b00,
		SBFW_STREAM = 2'b01,
		SBFW_STOP   = 2'b10,
		SBFW_TRIG   = 2'b11
	} sbfw_mode_t;

	typedef enum logic [1:0] {
		SBFW_ARMED = 2'b00,
		SBFW_POST  = 2'b01,
		SBFW_HALT  = 2'b10
	} sbfw_phase_t;

	// ****************************************************************
	// Software-visible control fields
	// ****************************************************************
	typedef struct packed {
		logic       keep_awake_select;
		logic [5:0] fill_threshold;
	} sbfw_ctrl_t;

	// Buffer flags plus fill count
	typedef struct packed {
		logic       watermark;
		logic       overrun_flag;
		logic [5:0] fill;
	} sbfw_stat_t;

endpackage : sbfw_pkg

`default_nettype wire

// ==== verification/sbfw_buffer_ctrl_checker.sv ====
// Port assertions for the sample buffer control block
`timescale 1ns/1ps
`default_nettype none

module sbfw_chk (
	input wire logic       CLK,
	input wire logic       NRST,
	input wire logic [7:0] REG_ADDR,
	input wire logic       REG_WR,
	input wire logic [7:0] REG_WDATA,
	input wire logic [1:0] BUF_MODE,
	input wire logic       POP_REQ,
	input wire logic [5:0] FILL_COUNT,
	input wire logic       WATERMARK_FLAG,
	input wire logic       OVERRUN_FLAG,
	input wire logic       TIMER_EXPIRED,
	input wire logic       TIMER_RESTART,
	input wire logic       SLEEP_ENTER,
	input wire logic       BUF_ACTIVITY,
	input wire logic       GATE_CLEAR
);
	logic       pw;
	logic       purge;
	logic       sel;
	logic [5:0] thr;
	logic       flag;

	// Control write decode
	assign pw = REG_WR && REG_ADDR == 8'h27;
	assign purge = pw && REG_WDATA[7];
	assign flag = WATERMARK_FLAG || OVERRUN_FLAG;

	// Shadow of the control fields, to predict the flags
	always_ff @(posedge CLK)
	begin
		if (!NRST)
			{sel, thr} <= 7'h00;
		else if (pw)
			{sel, thr} <= REG_WDATA[6:0];
	end

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!NRST);

	// ****************************************************************
	// Assertions
	// ****************************************************************
	purge_clears_a: assert property (purge |=> FILL_COUNT == 6'h00
		&& !flag && GATE_CLEAR) else $error("purge left state");
	wm_zero_a: assert property (thr == 6'h00 |-> !WATERMARK_FLAG)
		else $error("watermark with zero threshold");
	wm_level_a: assert property (thr != 6'h00 && $stable(thr)
		&& $stable(FILL_COUNT) |-> WATERMARK_FLAG == (FILL_COUNT >= thr))
		else $error("watermark level wrong");
	wake_off_a: assert property (!sel && !$past(sel) |-> !BUF_ACTIVITY)
		else $error("activity with select low");
	mode_gate_a: assert property (BUF_MODE[1] == BUF_MODE[0]
		&& $stable(BUF_MODE) |-> !BUF_ACTIVITY) else $error("activity in mode");
	sleep_on_a: assert property (TIMER_EXPIRED && !pw && !POP_REQ
		|=> SLEEP_ENTER) else $error("no sleep on expiry");
	restart_a: assert property (TIMER_EXPIRED && purge && sel && flag
		&& BUF_MODE[1] != BUF_MODE[0] |=> TIMER_RESTART && !SLEEP_ENTER)
		else $error("no restart on purge");
	mode_off_a: assert property (BUF_MODE == 2'b00 |=> FILL_COUNT == 6'h00
		&& !flag) else $error("store not flushed");

	// Main scenarios
	cover property (purge);
	cover property (TIMER_RESTART);
	cover property ($rose(OVERRUN_FLAG));
endmodule : sbfw_chk

`default_nettype wire

// ==== verification/sbfw_host_model.sv ====
// Host model: register strobes and sample reads
`timescale 1ns/1ps
`default_nettype none

module sbfw_host (
	input  wire logic       CLK,
	input  wire logic [7:0] REG_RDATA,
	output logic      [7:0] REG_ADDR,
	output logic            REG_WR,
	output logic      [7:0] REG_WDATA,
	output logic            REG_RD,
	output logic            POP_REQ
);
	// Quiet bus at time zero
	initial
	begin
		{REG_ADDR, REG_WDATA} = 16'h0000;
		{REG_WR, REG_RD, POP_REQ} = 3'h0;
	end

	// Write strobe held over one edge; bus then shows junk
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		// Idle edge first, so back-to-back calls never re-drive in one step
		@(posedge CLK);
		#1;
		REG_ADDR = a;
		REG_WDATA = v;
		REG_WR = 1'b1;
		@(posedge CLK);
		#1;
		REG_WR = 1'b0;
		REG_ADDR = ~a;
		REG_WDATA = ~v;
	endtask : wr

	// Read data is registered, so it is taken just after the edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		// Idle edge first, so back-to-back calls never re-drive in one step
		@(posedge CLK);
		#1;
		REG_ADDR = a;
		REG_RD = 1'b1;
		@(posedge CLK);
		#1;
		REG_RD = 1'b0;
		REG_ADDR = ~a;
		d = REG_RDATA;
	endtask : rd

	// One sample read
	task automatic pop;
		// Idle edge first, so back-to-back calls never re-drive in one step
		@(posedge CLK);
		#1;
		POP_REQ = 1'b1;
		@(posedge CLK);
		#1;
		POP_REQ = 1'b0;
	endtask : pop
endmodule : sbfw_host

`default_nettype wire

// ==== verification/sbfw_buffer_ctrl_tb_top.sv ====
// Self-checking bench for the sample buffer control block
`timescale 1ns/1ps
`default_nettype none

module sbfw_buffer_ctrl_tb_top;
	logic        clk;
	logic        nrst;
	logic [7:0]  ra;
	logic        rw;
	logic [7:0]  wd;
	logic        rr;
	logic [7:0]  rd;
	logic [1:0]  mode;
	logic        trig;
	logic        sv;
	logic [35:0] sd;
	logic        srdy;
	logic        pr;
	logic [35:0] pd;
	logic        pv;
	logic [5:0]  fill;
	logic        wm;
	logic        ovr;
	logic        tmr;
	logic        rst_t;
	logic        slp;
	logic        act;
	logic        gate;
	logic [7:0]  d;
	int          mismatches;
	int          compares;

	sbfw_buffer_ctrl uut (.CLK(clk), .NRST(nrst), .REG_ADDR(ra),
		.REG_WR(rw), .REG_WDATA(wd), .REG_RD(rr), .REG_RDATA(rd),
		.BUF_MODE(mode), .TRIG_EVENT(trig), .S_VALID(sv), .S_DATA(sd),
		.S_READY(srdy), .POP_REQ(pr), .POP_DATA(pd), .POP_VALID(pv),
		.FILL_COUNT(fill), .WATERMARK_FLAG(wm), .OVERRUN_FLAG(ovr),
		.TIMER_EXPIRED(tmr), .TIMER_RESTART(rst_t), .SLEEP_ENTER(slp),
		.BUF_ACTIVITY(act), .GATE_CLEAR(gate));

	sbfw_host host (.CLK(clk), .REG_RDATA(rd), .REG_ADDR(ra), .REG_WR(rw),
		.REG_WDATA(wd), .REG_RD(rr), .POP_REQ(pr));

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		compares++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	// Offer n words; ready is stable between edges, so count it here
	task automatic push(input int n);
		int k;
		k = 0;
		sv = 1'b1;
		while (k < n)
		begin
			if (srdy === 1'b1)
				k++;
			sd = 36'(k);
			tick(1);
		end
		sv = 1'b0;
		tick(3);
	endtask : push

	task automatic t_regs;
		host.rd(8'h27, d);
		chk("ctrl", 8'h00, d);
		host.wr(8'h27, 8'h85);
		host.rd(8'h27, d);
		chk("ctrl", 8'h05, d);
		host.rd(8'h10, d);
		chk("nomap", 8'h00, d);
		$display("regs done");
	endtask : t_regs

	task automatic t_wmark;
		host.wr(8'h27, 8'h03);
		push(2);
		chk("wm", 8'h00, {7'h00, wm});
		push(1);
		chk("fill", 8'h03, {2'h0, fill});
		chk("wm", 8'h01, {7'h00, wm});
		host.wr(8'h27, 8'h00);
		tick(1);
		chk("wm", 8'h00, {7'h00, wm});
		$display("wmark done");
	endtask : t_wmark

	task automatic t_wake;
		host.wr(8'h27, 8'h42);
		tick(1);
		chk("act", 8'h01, {7'h00, act});
		// Expiry held high across the pop and the purge below
		tmr = 1'b1;
		tick(1);
		chk("sleep", 8'h01, {7'h00, slp});
		host.pop();
		chk("pvalid", 8'h01, {7'h00, pv});
		chk("pdata", 8'h01, pd[7:0]);
		chk("restart", 8'h01, {7'h00, rst_t});
		chk("sleep", 8'h00, {7'h00, slp});
		host.wr(8'h27, 8'hc2);
		tmr = 1'b0;
		chk("restart", 8'h01, {7'h00, rst_t});
		chk("gate", 8'h01, {7'h00, gate});
		chk("fill", 8'h00, {2'h0, fill});
		$display("wake done");
	endtask : t_wake

	task automatic t_trig;
		mode = 2'b11;
		host.wr(8'h27, 8'h84);
		push(6);
		chk("fill", 8'h04, {2'h0, fill});
		trig = 1'b1;
		tick(1);
		trig = 1'b0;
		push(30);
		chk("fill", 8'h20, {2'h0, fill});
		chk("ovr", 8'h01, {7'h00, ovr});
		mode = 2'b00;
		tick(2);
		chk("fill", 8'h00, {2'h0, fill});
		chk("ovr", 8'h00, {7'h00, ovr});
		$display("trig done");
	endtask : t_trig

	// Stop policy: full store stalls the source and raises overrun
	task automatic t_stop;
		mode = 2'b10;
		host.wr(8'h27, 8'h44);
		push(34);
		chk("fill", 8'h20, {2'h0, fill});
		chk("wm", 8'h01, {7'h00, wm});
		chk("ovr", 8'h01, {7'h00, ovr});
		chk("srdy", 8'h00, {7'h00, srdy});
		chk("act", 8'h01, {7'h00, act});
		host.wr(8'h27, 8'h84);
		chk("restart", 8'h01, {7'h00, rst_t});
		chk("fill", 8'h00, {2'h0, fill});
		chk("srdy", 8'h01, {7'h00, srdy});
		$display("stop done");
	endtask : t_stop

	task automatic test_done;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : test_done

	// Free-running clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Whole run is under two hundred cycles; a hang ends here
	initial
	begin
		repeat (5000) @(posedge clk);
		mismatches++;
		test_done();
	end

	// Main sequence
	initial
	begin
		{nrst, trig, sv, tmr, sd} = 40'h0;
		{mismatches, compares} = 64'h0;
		mode = 2'b01;
		tick(16);
		nrst = 1'b1;
		tick(1);
		t_regs();
		t_wmark();
		t_wake();
		t_trig();
		t_stop();
		test_done();
	end
endmodule : sbfw_buffer_ctrl_tb_top

bind sbfw_buffer_ctrl sbfw_chk chk_i (.CLK, .NRST, .REG_ADDR, .REG_WR,
	.REG_WDATA, .BUF_MODE, .POP_REQ, .FILL_COUNT, .WATERMARK_FLAG,
	.OVERRUN_FLAG, .TIMER_EXPIRED, .TIMER_RESTART, .SLEEP_ENTER,
	.BUF_ACTIVITY, .GATE_CLEAR);

`default_nettype wire
